// File: include/fwd_pkg.sv
// Constants and carrier types for the store buffer and load forwarding block.
// Assumes one core clock; addresses are byte addresses, accesses are 1 to 8 bytes.
package fwd_pkg;
  localparam int ADDR_W = 32;
  localparam int DATA_W = 64;
  localparam int SIZE_W = 4;
  localparam int LINE_BYTES = 64;
  localparam int CHUNK_BYTES = 16;
  localparam int SB_DEPTH = 8;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [SIZE_W-1:0] size;
  } mem_op_t;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [SIZE_W-1:0] size;
    logic [DATA_W-1:0] data;
  } cache_wr_t;

  typedef struct packed {
    logic busy;
    logic retired;
    logic data_ok;
    logic [ADDR_W-1:0] addr;
    logic [SIZE_W-1:0] size;
    logic [DATA_W-1:0] data;
  } sb_entry_t;

  typedef enum logic [1:0] {
    LD_IDLE = 2'b00,
    LD_CHECK = 2'b01,
    LD_CACHE = 2'b10,
    LD_DONE = 2'b11
  } ld_state_t;
endpackage

// File: logic/store_fwd.sv
// Store buffer with commit to the data cache and store-to-load forwarding.
// Assumes loads and stores are presented in program order; one load in flight at a time.
`timescale 1ns/10ps
`default_nettype none
module store_fwd #(
  parameter int DEPTH = fwd_pkg::SB_DEPTH
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic st_alloc_valid,
  input wire fwd_pkg::mem_op_t st_alloc,
  output logic st_alloc_ready_q,
  output logic [$clog2(DEPTH)-1:0] st_alloc_idx_q,
  input wire logic sd_valid,
  input wire logic [$clog2(DEPTH)-1:0] sd_idx,
  input wire logic [fwd_pkg::DATA_W-1:0] sd_data,
  input wire logic st_retire,
  output logic cw_valid_q,
  output fwd_pkg::cache_wr_t cw_q,
  input wire logic cw_ack,
  input wire logic ld_valid,
  input wire fwd_pkg::mem_op_t ld_req,
  input wire logic ld_at_retire,
  output logic ld_ready_q,
  output logic ld_done_q,
  output logic [fwd_pkg::DATA_W-1:0] ld_data_q,
  output logic ld_fwd_q,
  output logic cr_valid_q,
  output fwd_pkg::mem_op_t cr_q,
  input wire logic cr_done,
  input wire logic [fwd_pkg::DATA_W-1:0] cr_data
);
  import fwd_pkg::*;
  localparam int IW = $clog2(DEPTH);

  // Bytes of an access that lie before the next boundary of the given size
  function automatic logic [SIZE_W-1:0] first_len(input logic [ADDR_W-1:0] a,
      input logic [SIZE_W-1:0] s, input int unsigned bnd);
    logic [ADDR_W:0] room;
    room = 33'(bnd) - 33'(a % bnd);
    first_len = (room < 33'(s)) ? room[SIZE_W-1:0] : s;
  endfunction

  function automatic logic crosses(input logic [ADDR_W-1:0] a, input logic [SIZE_W-1:0] s,
      input int unsigned bnd);
    crosses = first_len(a, s, bnd) != s;
  endfunction

  function automatic logic [DATA_W-1:0] byte_mask(input logic [SIZE_W-1:0] n);
    byte_mask = (n >= SIZE_W'(8)) ? '1 : ~({DATA_W{1'b1}} << {n, 3'b000});
  endfunction

  // Store buffer state
  sb_entry_t [DEPTH-1:0] sb_q, sb_d;
  logic [IW-1:0] head_q, head_d, tail_q, tail_d, rp_q, rp_d;
  logic [IW:0] cnt_q, cnt_d;
  logic cw_valid_d, cw_part_q, cw_part_d, pop;
  cache_wr_t cw_d;
  logic [SIZE_W-1:0] cw_len;

  always_comb begin
    sb_d = sb_q;
    head_d = head_q;
    tail_d = tail_q;
    rp_d = rp_q;
    cnt_d = cnt_q;
    cw_valid_d = cw_valid_q;
    cw_part_d = cw_part_q;
    cw_d = cw_q;
    pop = 1'b0;
    cw_len = first_len(sb_q[head_q].addr, sb_q[head_q].size, LINE_BYTES);
    if (sd_valid && sb_q[sd_idx].busy) begin
      sb_d[sd_idx].data = sd_data;
      sb_d[sd_idx].data_ok = 1'b1;
    end
    if (st_retire && sb_q[rp_q].busy && !sb_q[rp_q].retired) begin
      sb_d[rp_q].retired = 1'b1;
      rp_d = rp_q + 1'b1;
    end
    if (cw_valid_q) begin
      if (cw_ack) begin
        cw_valid_d = 1'b0;
        if (!cw_part_q && crosses(sb_q[head_q].addr, sb_q[head_q].size, LINE_BYTES)) begin
          // Second half of a line-crossing store starts at the next line
          cw_valid_d = 1'b1;
          cw_part_d = 1'b1;
          cw_d.addr = sb_q[head_q].addr + ADDR_W'(cw_len);
          cw_d.size = sb_q[head_q].size - cw_len;
          cw_d.data = (sb_q[head_q].data >> {cw_len, 3'b000}) &
                      byte_mask(sb_q[head_q].size - cw_len);
        end else begin
          pop = 1'b1;
          cw_part_d = 1'b0;
        end
      end
    end else if (sb_q[head_q].busy && sb_q[head_q].retired && sb_q[head_q].data_ok) begin
      // Only retired stores with data may leave for the cache
      cw_valid_d = 1'b1;
      cw_d.addr = sb_q[head_q].addr;
      cw_d.size = cw_len;
      cw_d.data = sb_q[head_q].data & byte_mask(cw_len);
    end
    if (pop) begin
      sb_d[head_q].busy = 1'b0;
      head_d = head_q + 1'b1;
    end
    if (st_alloc_valid && st_alloc_ready_q) begin
      sb_d[tail_q] = '{busy: 1'b1, retired: 1'b0, data_ok: 1'b0, addr: st_alloc.addr,
                       size: st_alloc.size, data: '0};
      tail_d = tail_q + 1'b1;
    end
    cnt_d = cnt_q + (IW+1)'(st_alloc_valid && st_alloc_ready_q) - (IW+1)'(pop);
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      sb_q <= '0;
      head_q <= '0;
      tail_q <= '0;
      rp_q <= '0;
      cnt_q <= '0;
      cw_valid_q <= 1'b0;
      cw_part_q <= 1'b0;
      cw_q <= '0;
      st_alloc_ready_q <= 1'b0;
      st_alloc_idx_q <= '0;
    end else begin
      sb_q <= sb_d;
      head_q <= head_d;
      tail_q <= tail_d;
      rp_q <= rp_d;
      cnt_q <= cnt_d;
      cw_valid_q <= cw_valid_d;
      cw_part_q <= cw_part_d;
      cw_q <= cw_d;
      st_alloc_ready_q <= cnt_d < (IW+1)'(DEPTH);
      st_alloc_idx_q <= tail_d;
    end
  end

  // Load side
  ld_state_t st_q, st_d;
  mem_op_t ld_q, ld_d;
  logic [DEPTH-1:0] older_q, older_d;
  logic ld_ready_d, ld_done_d, ld_fwd_d, cr_valid_d, cr_part_q, cr_part_d;
  logic [DATA_W-1:0] ld_data_d, rd0_q, rd0_d;
  mem_op_t cr_d;
  logic hit, hit_fwd, hit_dok, split_line, odd_bnd;
  logic [IW-1:0] idx;
  logic [DATA_W-1:0] hit_data;
  logic [ADDR_W:0] ld_end, st_end;
  logic [SIZE_W-1:0] ld_len;

  always_comb begin
    hit = 1'b0;
    hit_fwd = 1'b0;
    hit_dok = 1'b0;
    hit_data = '0;
    idx = '0;
    st_end = '0;
    ld_end = {1'b0, ld_q.addr} + (ADDR_W+1)'(ld_q.size);
    // Walk oldest to youngest so the last match is the youngest older store
    for (int k = 0; k < DEPTH; k++) begin
      idx = head_q + IW'(k);
      st_end = {1'b0, sb_q[idx].addr} + (ADDR_W+1)'(sb_q[idx].size);
      if (older_q[idx] && sb_q[idx].busy && ({1'b0, ld_q.addr} < st_end) &&
          ({1'b0, sb_q[idx].addr} < ld_end)) begin
        hit = 1'b1;
        hit_fwd = (sb_q[idx].addr == ld_q.addr) &&
                  (ld_q.size <= sb_q[idx].size);
        hit_dok = sb_q[idx].data_ok;
        hit_data = sb_q[idx].data;
      end
    end
    split_line = crosses(ld_q.addr, ld_q.size, LINE_BYTES);
    odd_bnd = split_line || crosses(ld_q.addr, ld_q.size, CHUNK_BYTES);
    ld_len = first_len(ld_q.addr, ld_q.size, LINE_BYTES);
  end

  always_comb begin
    st_d = st_q;
    ld_d = ld_q;
    older_d = older_q;
    ld_ready_d = 1'b0;
    ld_done_d = 1'b0;
    ld_fwd_d = ld_fwd_q;
    ld_data_d = ld_data_q;
    cr_valid_d = cr_valid_q;
    cr_part_d = cr_part_q;
    cr_d = cr_q;
    rd0_d = rd0_q;
    if (pop) begin
      older_d[head_q] = 1'b0;
    end
    case (st_q)
      LD_IDLE: begin
        ld_ready_d = 1'b1;
        if (ld_valid && ld_ready_q) begin
          ld_ready_d = 1'b0;
          ld_d = ld_req;
          ld_fwd_d = 1'b0;
          // Stores present now are older; later ones are ignored by this load
          for (int k = 0; k < DEPTH; k++) begin
            older_d[k] = sb_d[k].busy;
          end
          st_d = LD_CHECK;
        end
      end
      LD_CHECK: begin
        if (odd_bnd && !ld_at_retire) begin
          st_d = LD_CHECK;
        end else if (hit && hit_fwd && hit_dok) begin
          // Forward without a cache read
          ld_data_d = hit_data & byte_mask(ld_q.size);
          ld_fwd_d = 1'b1;
          ld_done_d = 1'b1;
          st_d = LD_DONE;
        end else if (hit) begin
          // Forwardable: wait for store data; otherwise wait for commit
          st_d = LD_CHECK;
        end else begin
          cr_valid_d = 1'b1;
          cr_part_d = 1'b0;
          cr_d.addr = ld_q.addr;
          cr_d.size = ld_len;
          st_d = LD_CACHE;
        end
      end
      LD_CACHE: begin
        if (cr_done) begin
          if (!cr_part_q && split_line) begin
            // Second cache access for the part in the next line
            rd0_d = cr_data & byte_mask(ld_len);
            cr_part_d = 1'b1;
            cr_d.addr = ld_q.addr + ADDR_W'(ld_len);
            cr_d.size = ld_q.size - ld_len;
          end else begin
            cr_valid_d = 1'b0;
            ld_data_d = cr_part_q ?
                        (rd0_q | ((cr_data & byte_mask(cr_q.size)) << {ld_len, 3'b000})) :
                        (cr_data & byte_mask(ld_q.size));
            ld_done_d = 1'b1;
            st_d = LD_DONE;
          end
        end
      end
      LD_DONE: begin
        ld_ready_d = 1'b1;
        st_d = LD_IDLE;
      end
      default: begin
        st_d = LD_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      st_q <= LD_IDLE;
      ld_q <= '0;
      older_q <= '0;
      ld_ready_q <= 1'b0;
      ld_done_q <= 1'b0;
      ld_fwd_q <= 1'b0;
      ld_data_q <= '0;
      cr_valid_q <= 1'b0;
      cr_part_q <= 1'b0;
      cr_q <= '0;
      rd0_q <= '0;
    end else begin
      st_q <= st_d;
      ld_q <= ld_d;
      older_q <= older_d;
      ld_ready_q <= ld_ready_d;
      ld_done_q <= ld_done_d;
      ld_fwd_q <= ld_fwd_d;
      ld_data_q <= ld_data_d;
      cr_valid_q <= cr_valid_d;
      cr_part_q <= cr_part_d;
      cr_q <= cr_d;
      rd0_q <= rd0_d;
    end
  end
endmodule
`default_nettype wire

// File: verif/store_fwd_asserts.sv
// Port timing checker for store_fwd.
// Assumes it is bound to every store_fwd instance.
`timescale 1ns/10ps
`default_nettype none
module store_fwd_asserts (
  input wire logic clk,
  input wire logic nrst,
  input wire logic ld_valid,
  input wire logic ld_ready_q,
  input wire logic ld_done_q,
  input wire logic ld_fwd_q,
  input wire logic cw_valid_q,
  input wire fwd_pkg::cache_wr_t cw_q,
  input wire logic cw_ack,
  input wire logic cr_valid_q,
  input wire fwd_pkg::mem_op_t cr_q,
  input wire logic cr_done
);
  import fwd_pkg::*;
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  sequence s_take; ld_valid && ld_ready_q; endsequence
  sequence s_wr_wait; cw_valid_q && !cw_ack; endsequence
  property p_take; s_take |=> !ld_ready_q && !ld_done_q; endproperty
  property p_done; ld_done_q |=> !ld_done_q && ld_ready_q; endproperty
  property p_fwd; ld_done_q && ld_fwd_q |-> !cr_valid_q && !$past(cr_valid_q); endproperty
  property p_cache_done;
    ld_done_q && !ld_fwd_q |-> $past(cr_done) && $past(cr_valid_q);
  endproperty
  property p_cw_hold; s_wr_wait |=> cw_valid_q && $stable(cw_q); endproperty
  property p_cr_hold; cr_valid_q && !cr_done |=> cr_valid_q && $stable(cr_q); endproperty
  property p_cw_line; cw_valid_q |-> 7'(cw_q.addr[5:0]) + 7'(cw_q.size) <= 7'h40; endproperty
  property p_cr_line; cr_valid_q |-> 7'(cr_q.addr[5:0]) + 7'(cr_q.size) <= 7'h40; endproperty
  a_take: assert property (p_take) else $error("load answered too early");
  a_done: assert property (p_done) else $error("done not a pulse");
  a_fwd: assert property (p_fwd) else $error("forward used cache");
  a_cache_done: assert property (p_cache_done) else $error("done without read");
  a_cw_hold: assert property (p_cw_hold) else $error("write request moved");
  a_cr_hold: assert property (p_cr_hold) else $error("read request moved");
  a_cw_line: assert property (p_cw_line) else $error("write crosses line");
  a_cr_line: assert property (p_cr_line) else $error("read crosses line");
endmodule
bind store_fwd store_fwd_asserts i_store_fwd_asserts (.clk, .nrst, .ld_valid, .ld_ready_q,
  .ld_done_q, .ld_fwd_q, .cw_valid_q, .cw_q, .cw_ack, .cr_valid_q, .cr_q, .cr_done);
`default_nettype wire

// File: verif/cache_model.sv
// Data cache stand-in: takes writes and answers reads after 0 to 3 idle cycles.
// Assumes byte storage; unwritten bytes read as low address byte xor 5a.
`timescale 1ns/10ps
`default_nettype none
module cache_model (
  input wire logic clk,
  input wire logic nrst,
  input wire logic cw_valid_q,
  input wire fwd_pkg::cache_wr_t cw_q,
  output logic cw_ack,
  input wire logic cr_valid_q,
  input wire fwd_pkg::mem_op_t cr_q,
  output logic cr_done,
  output logic [fwd_pkg::DATA_W-1:0] cr_data
);
  import fwd_pkg::*;
  logic [7:0] mem [int unsigned];
  int wd = 0;
  int rd = 0;
  function automatic logic [7:0] rb(int unsigned a);
    return mem.exists(a) ? mem[a] : a[7:0] ^ 8'h5a;
  endfunction
  always @(posedge clk) begin
    cw_ack <= 1'b0;
    cr_done <= 1'b0;
    // Idle data toggles so a stale read cannot pass
    cr_data <= ~cr_data;
    if (!nrst) begin
      cr_data <= '0;
    end else begin
      if (cw_valid_q && !cw_ack) begin
        if (wd == 0) begin
          for (int k = 0; k < cw_q.size; k++) mem[cw_q.addr + k] = cw_q.data[8*k +: 8];
          cw_ack <= 1'b1;
          wd = $urandom % 4;
        end else wd--;
      end
      if (cr_valid_q && !cr_done) begin
        if (rd == 0) begin
          for (int k = 0; k < 8; k++) cr_data[8*k +: 8] <= rb(cr_q.addr + k);
          cr_done <= 1'b1;
          rd = $urandom % 4;
        end else rd--;
      end
    end
  end
endmodule
`default_nettype wire

// File: verif/store_fwd_bench.sv
// Bench for store_fwd: per case two stores, one load, then both stores retire.
// Assumes cache_model on the cache side; inputs change at the falling edge.
`timescale 1ns/10ps
`default_nettype none
module store_fwd_bench;
  import fwd_pkg::*;
  logic clk = 1'b0, nrst = 1'b0, st_alloc_valid = 1'b0, sd_valid = 1'b0, st_retire = 1'b0;
  logic ld_valid = 1'b0, ld_at_retire = 1'b0, dn_fwd, hung = 1'b0;
  logic st_alloc_ready_q, cw_valid_q, cw_ack, ld_ready_q, ld_done_q, ld_fwd_q, cr_valid_q, cr_done;
  mem_op_t st_alloc = '0, ld_req = '0, cr_q;
  cache_wr_t cw_q;
  logic [2:0] st_alloc_idx_q, sd_idx = '0;
  logic [63:0] sd_data = '0, ld_data_q, cr_data, dn_data;
  logic [7:0] sh [int unsigned];
  int bad_count = 0, num_checks = 0, cyc = 0, td = 0, seen = 0;
  localparam int TC [8][7] = '{'{'h100, 8, 'h200, 4, 'h100, 4, 0},
    '{'h100, 4, 'h200, 4, 'h100, 8, 0}, '{'h100, 8, 'h300, 4, 'h102, 2, 0},
    '{'h100, 8, 'h102, 2, 'h100, 4, 0}, '{'h101, 1, 'h100, 8, 'h100, 8, 5},
    '{'h200, 4, 'h300, 4, 'h13e, 4, 0}, '{'h13c, 8, 'h400, 1, 'h140, 2, 0},
    '{'h108, 4, 'h208, 4, 'h10e, 4, 0}};
  always #12.5 clk = ~clk;
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (ld_done_q === 1'b1) begin
      td <= cyc;
      seen <= seen + 1;
      dn_data <= ld_data_q;
      dn_fwd <= ld_fwd_q;
    end
  end
  store_fwd i_store_fwd (.clk, .nrst, .st_alloc_valid, .st_alloc, .st_alloc_ready_q,
    .st_alloc_idx_q, .sd_valid, .sd_idx, .sd_data, .st_retire, .cw_valid_q, .cw_q, .cw_ack,
    .ld_valid, .ld_req, .ld_at_retire, .ld_ready_q, .ld_done_q, .ld_data_q, .ld_fwd_q,
    .cr_valid_q, .cr_q, .cr_done, .cr_data);
  cache_model i_cache_model (.clk, .nrst, .cw_valid_q, .cw_q, .cw_ack, .cr_valid_q, .cr_q,
    .cr_done, .cr_data);
  function automatic logic [7:0] eb(int unsigned a);
    return sh.exists(a) ? sh[a] : a[7:0] ^ 8'h5a;
  endfunction
  function automatic logic ovl(mem_op_t a, mem_op_t b);
    return a.addr < b.addr + b.size && b.addr < a.addr + a.size;
  endfunction
  function automatic mem_op_t ro();
    ro.addr = 32'h1038 + $urandom % 12;
    ro.size = 4'(1 + $urandom % 8);
  endfunction
  task automatic chk(string n, logic [63:0] e, logic [63:0] s);
    num_checks++;
    if (s !== e) begin
      bad_count++;
      $display("MISMATCH %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic end_sim();
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic alloc(mem_op_t s, logic [63:0] d, output logic [2:0] i);
    @(negedge clk);
    chk("st_alloc_ready", 64'h1, 64'(st_alloc_ready_q));
    i = st_alloc_idx_q;
    st_alloc_valid = 1'b1;
    st_alloc = s;
    for (int k = 0; k < s.size; k++) sh[s.addr + k] = d[8*k +: 8];
    @(negedge clk);
    st_alloc_valid = 1'b0;
  endtask
  task automatic sdat(logic [2:0] i, logic [63:0] d);
    @(negedge clk);
    sd_valid = 1'b1;
    sd_idx = i;
    sd_data = d;
    @(negedge clk);
    sd_valid = 1'b0;
    sd_data = ~d;
  endtask
  task automatic run(mem_op_t s0, mem_op_t s1, mem_op_t ld, int dly);
    logic [2:0] i0, i1;
    logic [63:0] d0, d1, ed;
    mem_op_t y;
    logic ef, cr, early;
    int t1, tl, sn;
    d0 = {$urandom, $urandom};
    d1 = {$urandom, $urandom};
    alloc(s0, d0, i0);
    alloc(s1, d1, i1);
    sdat(i0, d0);
    y = ovl(s1, ld) ? s1 : s0;
    ef = ovl(y, ld) && y.addr == ld.addr && ld.size <= y.size;
    cr = 5'(ld.addr[3:0]) + 5'(ld.size) > 5'h10;
    early = !cr && (ef || !ovl(s0, ld) && !ovl(s1, ld));
    ed = '0;
    for (int k = 0; k < ld.size; k++) ed[8*k +: 8] = eb(ld.addr + k);
    sn = seen;
    @(negedge clk);
    chk("ld_ready", 64'h1, 64'(ld_ready_q));
    ld_valid = 1'b1;
    ld_req = ld;
    @(negedge clk);
    ld_valid = 1'b0;
    repeat (dly) @(negedge clk);
    t1 = cyc;
    sdat(i1, d1);
    // Margin lets a cache-path load finish before the stores may commit
    repeat (10) @(negedge clk);
    ld_at_retire = 1'b1;
    st_retire = 1'b1;
    tl = cyc;
    @(negedge clk);
    st_retire = 1'b0;
    @(negedge clk);
    st_retire = 1'b1;
    @(negedge clk);
    st_retire = 1'b0;
    for (int k = 0; k < 200 && seen == sn; k++) @(negedge clk);
    if (seen == sn) begin
      bad_count++;
      $display("MISMATCH load_done expected 1 seen 0");
      hung = 1'b1;
      return;
    end
    chk("ld_data", ed, dn_data);
    if (!cr) chk("ld_fwd", 64'(ef), 64'(dn_fwd));
    chk("ld_early", 64'(early), 64'(td < tl));
    if (ef && y === s1) chk("fwd_after_data", 64'h1, 64'(td > t1 + 1));
    ld_at_retire = 1'b0;
    repeat (30) @(negedge clk);
    $display("case done fwd %0d early %0d", ef, early);
  endtask
  initial begin
    void'($urandom(80));
    repeat (2) @(negedge clk);
    nrst = 1'b1;
    repeat (2) @(negedge clk);
    for (int i = 0; i < 8 && !hung; i++) run({32'(TC[i][0]), 4'(TC[i][1])}, {32'(TC[i][2]),
      4'(TC[i][3])}, {32'(TC[i][4]), 4'(TC[i][5])}, TC[i][6]);
    for (int i = 0; i < 40 && !hung; i++) run(ro(), ro(), ro(), $urandom % 4);
    end_sim();
  end
endmodule
`default_nettype wire
